// ==== verilog/jbs_sequencer.sv ====
// jump and block copy sequencer: return jump tail, block copy, exchange jump hold
// Operation
// - return jump issue sets flags, loads fetch address
// - next period: stack address, waits, first request
// - two periods later: second request, first leaves
// - blank words and outstanding while no match
// - first word stacked, tags shifted, wait two cleared
// - match next period loads word, clears outstanding
// - second word stacked, wait one cleared
// - store exit waits for wait one clear
// - store exit request held until backup resolved
// - first request held during stage backup
// - busy bank delays first word arrival
// - block copy holds current word until done
// - copy starts on free, pending clear, request, enable
// - coupler requested three periods after start
// - normal end: p+1 later, issue, next
// - range error: end, error, p+1, issue
// - error end loads next instruction, not new word
// - both copy directions share identical timing
// - exchange jump holds at least 91 periods
// - exchange issue loads all-zero current word
// - exchange clears tags, blocks issue until reload
`timescale 1ns/100ps
module jbs_sequencer
   import jbs_pkg::*;
#(
   parameter int ADDR_WIDTH = ADDR_W,
   parameter int DEPTH = STACK_D
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic rj_start,          // return jump reaches issue period
   input wire logic bc_start_req,      // block copy in current word (either direction)
   input wire logic ext_store_req,     // extended store request
   input wire logic regs_free,         // all operating registers free
   input wire logic coupler_range_err, // extended store range error
   input wire logic coupler_eot,       // coupler end of transfer
   input wire logic xfer_err_end,      // transfer ended by extended store error
   input wire logic pp_xchg_req,       // peripheral processors exchange request
   input wire logic xj_start,          // exchange jump in current word
   input wire logic xj_done,           // exchange done and stack reloaded
   input wire logic [ADDR_W-1:0] prog_addr,
   input wire logic [ADDR_W-1:0] memory_base_address,
   input wire logic [WORD_W-1:0] fetch_word,
   input wire logic fetch_word_valid,
   input wire logic [WORD_W-1:0] next_instr_word,
   input wire jbs_mstat_t mstat,
   output jbs_mreq_t mreq,
   output logic [WORD_W-1:0] current_word_reg,
   output logic issue,
   output logic coupler_req,
   output logic eot_to_ctrl,
   output logic range_error,
   output logic p_incr,
   output logic fetch_outstanding_flag,
   output logic jump_out_flag,
   output logic fetch_pending_one,
   output logic fetch_pending_two,
   output logic memory_wait_one,
   output logic memory_wait_two,
   output logic store_exit_flag,
   output logic [ADDR_W-1:0] next_stack_address
);
   // ----------------------------------------------------------------
   // sequence states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      S_IDLE, S_RJ_SX, S_RJ_REQ1, S_RJ_GAP, S_RJ_REQ2, S_RJ_WAIT, S_RJ_MATCH,
      S_BC_WAIT, S_BC_RUN, S_BC_END, S_BC_ERR, S_BC_ISSUE, S_XJ
   } jbs_state_t;

   jbs_state_t st_ff, nxt_st;                // sequence state
   logic [6:0] cnt_ff, nxt_cnt;              // step counter within a state
   logic [ADDR_W-1:0] ifa_ff, nxt_ifa;       // fetch address register
   logic [ADDR_W-1:0] nsa_ff, nxt_nsa;       // next stack address
   logic [WORD_W-1:0] cw_ff, nxt_cw;         // current word register
   logic osf_ff, nxt_osf;
   logic jof_ff, nxt_jof;
   logic f1_ff, nxt_f1;
   logic f2_ff, nxt_f2;
   logic m1_ff, nxt_m1;
   logic m2_ff, nxt_m2;
   logic sx_ff, nxt_sx;
   logic err_ff, nxt_err;                    // block copy ended by range error
   logic xerr_ff, nxt_xerr;                  // transfer ended by store error
   logic [1:0] words_ff, nxt_words;          // fetched words stacked so far
   logic [WORD_W-1:0] iws_ff [DEPTH];        // instruction word stack
   logic [TAG_W-1:0] tag_ff [DEPTH];         // stack address tags
   logic stk_shift;                          // shift stack one word position
   logic tags_clear;                         // void all stack tags
   logic hit;                                // tag coincidence on head entry

   assign hit = (tag_ff[0] == nsa_ff - ADDR_ONE) && (words_ff != 2'h0);

   // ----------------------------------------------------------------
   // sequence next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_ifa = ifa_ff;
      nxt_nsa = nsa_ff;
      nxt_cw = cw_ff;
      nxt_osf = osf_ff;
      nxt_jof = jof_ff;
      nxt_f1 = f1_ff;
      nxt_f2 = f2_ff;
      nxt_m1 = m1_ff;
      nxt_m2 = m2_ff;
      nxt_sx = 1'b0;
      nxt_err = err_ff;
      nxt_xerr = xerr_ff;
      nxt_words = words_ff;
      mreq = '0;
      issue = 1'b0;
      coupler_req = 1'b0;
      eot_to_ctrl = 1'b0;
      range_error = 1'b0;
      p_incr = 1'b0;
      stk_shift = 1'b0;
      tags_clear = 1'b0;
      // words arriving from main storage are stacked in order
      if (fetch_word_valid && !mstat.bank_busy) begin
         stk_shift = 1'b1;
         nxt_nsa = nsa_ff + ADDR_ONE;
         nxt_words = words_ff + 2'h1;
         if (words_ff == 2'h0) begin
            nxt_m2 = 1'b0;
         end else begin
            nxt_m1 = 1'b0;
         end
      end
      unique case (st_ff)
         // waiting for an instruction to sequence
         S_IDLE: begin
            if (xj_start) begin
               issue = 1'b1;
               nxt_cw = BLANK_WORD;
               tags_clear = 1'b1;
               nxt_cnt = 7'h1;
               nxt_st = S_XJ;
            end else if (rj_start && !m1_ff) begin
               nxt_st = S_RJ_SX;
            end else if (bc_start_req && regs_free && !f1_ff && ext_store_req
                         && mstat.mem_enable_nxt) begin
               nxt_cnt = 7'h1;
               nxt_err = 1'b0;
               nxt_st = S_BC_WAIT;
            end
         end
         // store exit request period, held on backup
         S_RJ_SX: begin
            if ((!mstat.sas_backup && !mstat.mem_enable)
                || mstat.backup_resolved) begin
               nxt_sx = 1'b1;
               issue = 1'b1;
               nxt_jof = 1'b1;
               nxt_osf = 1'b1;
               nxt_f1 = 1'b1;
               nxt_f2 = 1'b1;
               nxt_ifa = prog_addr + memory_base_address;
               nxt_cw = BLANK_WORD;
               tags_clear = 1'b1;
               nxt_words = 2'h0;
               nxt_st = S_RJ_REQ1;
            end
         end
         // first fetch request to the storage address stage
         S_RJ_REQ1: begin
            nxt_cw = BLANK_WORD;
            if (!mstat.sas_backup) begin
               nxt_nsa = prog_addr;
               nxt_m1 = 1'b1;
               nxt_m2 = 1'b1;
               mreq = '{valid: 1'b1, tag: JBS_TAG_STACK, addr: ifa_ff};
               nxt_ifa = ifa_ff + ADDR_ONE;
               nxt_jof = 1'b0;
               nxt_f2 = 1'b0;
               nxt_cnt = 7'h1;
               nxt_st = S_RJ_GAP;
            end
         end
         // one idle period between the two requests
         S_RJ_GAP: begin
            nxt_cw = BLANK_WORD;
            nxt_cnt = cnt_ff + 7'h1;
            if (cnt_ff[1:0] == RJ_F1_GAP - 2'h1) begin
               nxt_st = S_RJ_REQ2;
            end
         end
         // second fetch request; first address leaves for main storage
         S_RJ_REQ2: begin
            nxt_cw = BLANK_WORD;
            if (!mstat.sas_backup) begin
               mreq = '{valid: 1'b1, tag: JBS_TAG_STACK, addr: ifa_ff};
               nxt_ifa = ifa_ff + ADDR_ONE;
               nxt_f1 = 1'b0;
               nxt_st = S_RJ_WAIT;
            end
         end
         // blank words until the first word is stacked
         S_RJ_WAIT: begin
            nxt_cw = BLANK_WORD;
            nxt_osf = 1'b1;
            // move on as the first word is stacked, so the match lands one period later
            if (stk_shift || (words_ff != 2'h0)) begin
               nxt_st = S_RJ_MATCH;
            end
         end
         // coincidence loads a valid word
         S_RJ_MATCH: begin
            if (hit) begin
               nxt_cw = iws_ff[0];
               nxt_osf = 1'b0;
               nxt_st = S_IDLE;
            end else begin
               nxt_cw = BLANK_WORD;
            end
         end
         // three periods to the coupler request
         S_BC_WAIT: begin
            nxt_cnt = cnt_ff + 7'h1;
            if (cnt_ff[1:0] == BC_REQ_DLY) begin
               if (coupler_range_err) begin
                  eot_to_ctrl = 1'b1;
                  nxt_err = 1'b1;
                  nxt_cnt = 7'h1;
                  nxt_st = S_BC_ERR;
               end else begin
                  coupler_req = 1'b1;
                  nxt_st = S_BC_RUN;
               end
            end
         end
         // coupler controls the transfer; word held in place
         S_BC_RUN: begin
            if (coupler_eot && !pp_xchg_req && mstat.mem_enable) begin
               nxt_xerr = xfer_err_end;
               nxt_cnt = 7'h1;
               nxt_st = S_BC_END;
            end
         end
         // normal end: p+1 two periods after end of transfer
         S_BC_END: begin
            nxt_cnt = cnt_ff + 7'h1;
            if (cnt_ff[1:0] == BC_END_DLY - 2'h1) begin
               p_incr = 1'b1;
               nxt_st = S_BC_ISSUE;
            end
         end
         // range error: error two periods on, p+1 two after
         S_BC_ERR: begin
            nxt_cnt = cnt_ff + 7'h1;
            if (cnt_ff[1:0] == BC_ERR_DLY) begin
               range_error = 1'b1;
            end
            if (cnt_ff[2:0] == {1'b0, BC_ERR_DLY} + {1'b0, BC_ERR_DLY}) begin
               p_incr = 1'b1;
               nxt_st = S_BC_ISSUE;
            end
         end
         // block copy issues, current word replaced
         S_BC_ISSUE: begin
            issue = 1'b1;
            nxt_cw = (xerr_ff || err_ff) ? next_instr_word : fetch_word;
            nxt_xerr = 1'b0;
            nxt_st = S_IDLE;
         end
         // exchange jump: nothing enters until done and minimum elapsed
         S_XJ: begin
            nxt_cw = BLANK_WORD;
            if (cnt_ff != XJ_MIN_CP) begin
               nxt_cnt = cnt_ff + 7'h1;
            end
            if (xj_done && cnt_ff == XJ_MIN_CP) begin
               nxt_st = S_IDLE;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // sequence registers; clock enable freezes every step
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         st_ff <= S_IDLE;
         cnt_ff <= 7'h0;
         ifa_ff <= '0;
         nsa_ff <= '0;
         cw_ff <= BLANK_WORD;
         osf_ff <= 1'b0;
         jof_ff <= 1'b0;
         f1_ff <= 1'b0;
         f2_ff <= 1'b0;
         m1_ff <= 1'b0;
         m2_ff <= 1'b0;
         sx_ff <= 1'b0;
         err_ff <= 1'b0;
         xerr_ff <= 1'b0;
         words_ff <= 2'h0;
      end else if (ce) begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         ifa_ff <= nxt_ifa;
         nsa_ff <= nxt_nsa;
         cw_ff <= nxt_cw;
         osf_ff <= nxt_osf;
         jof_ff <= nxt_jof;
         f1_ff <= nxt_f1;
         f2_ff <= nxt_f2;
         m1_ff <= nxt_m1;
         m2_ff <= nxt_m2;
         sx_ff <= nxt_sx;
         err_ff <= nxt_err;
         xerr_ff <= nxt_xerr;
         words_ff <= nxt_words;
      end
   end

   // ----------------------------------------------------------------
   // instruction word stack and address tags, one entry per generate
   // ----------------------------------------------------------------
   for (genvar i = 0; i < DEPTH; i++) begin : g_stk
      always_ff @(posedge mclk) begin
         if (!rstn) begin
            iws_ff[i] <= BLANK_WORD;
            tag_ff[i] <= TAG_CLEAR;
         end else if (ce) begin
            if (tags_clear) begin
               tag_ff[i] <= TAG_CLEAR;
            end else if (stk_shift) begin
               // new word enters at the head, older words move down
               iws_ff[i] <= (i == 0) ? fetch_word : iws_ff[(i == 0) ? 0 : i - 1];
               tag_ff[i] <= (i == 0) ? nsa_ff : tag_ff[(i == 0) ? 0 : i - 1];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs from registers
   // ----------------------------------------------------------------
   assign current_word_reg = cw_ff;
   assign fetch_outstanding_flag = osf_ff;
   assign jump_out_flag = jof_ff;
   assign fetch_pending_one = f1_ff;
   assign fetch_pending_two = f2_ff;
   assign memory_wait_one = m1_ff;
   assign memory_wait_two = m2_ff;
   assign store_exit_flag = sx_ff;
   assign next_stack_address = nsa_ff;

endmodule : jbs_sequencer

// ==== verilog/jbs_pkg.sv ====
// package for the jump and block copy sequencer: constants and carriers
package jbs_pkg;
   // ----------------------------------------------------------------
   // widths and reset values
   // ----------------------------------------------------------------
   localparam int ADDR_W = 18;           // instruction counter / address width
   localparam int WORD_W = 60;           // instruction word width
   localparam int TAG_W = 18;            // stack address tag width
   localparam int STACK_D = 8;           // instruction word stack depth
   localparam logic [WORD_W-1:0] BLANK_WORD = 60'h000000000000000;
   localparam logic [TAG_W-1:0] TAG_CLEAR = 18'h00000;
   localparam logic [ADDR_W-1:0] ADDR_ONE = 18'h00001;
   // ----------------------------------------------------------------
   // timing counts in clock periods
   // ----------------------------------------------------------------
   localparam logic [1:0] RJ_F1_GAP = 2'h2;     // first to second fetch request
   localparam logic [1:0] BC_REQ_DLY = 2'h3;    // start to coupler request
   localparam logic [1:0] BC_END_DLY = 2'h3;    // end of transfer to issue
   localparam logic [1:0] BC_ERR_DLY = 2'h2;    // range error spacing
   localparam logic [6:0] XJ_MIN_CP = 7'h5b;    // exchange jump minimum, 91 periods
   // ----------------------------------------------------------------
   // memory request tags toward the storage address stage
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {JBS_TAG_NONE, JBS_TAG_STACK} jbs_tag_t;
   // memory side request carrier
   typedef struct packed {
      logic valid;
      jbs_tag_t tag;
      logic [ADDR_W-1:0] addr;
   } jbs_mreq_t;
   // memory side status carrier
   typedef struct packed {
      logic sas_backup;     // storage address stage backed up
      logic mem_enable;     // memory enable this period
      logic mem_enable_nxt; // memory enable next period
      logic backup_resolved;
      logic bank_busy;      // first fetch bank still busy
      logic addr_leave;     // address accepted by main storage
   } jbs_mstat_t;
endpackage : jbs_pkg

// ==== verif/jbs_sequencer_sva.sv ====
// assertions on the sequencer ports
`timescale 1ns/100ps
module jbs_sequencer_sva
   import jbs_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic rj_start,
   input wire logic bc_start_req,
   input wire logic ext_store_req,
   input wire logic regs_free,
   input wire logic coupler_range_err,
   input wire logic coupler_eot,
   input wire logic pp_xchg_req,
   input wire logic fetch_word_valid,
   input wire jbs_mstat_t mstat,
   input wire jbs_mreq_t mreq,
   input wire logic [WORD_W-1:0] current_word_reg,
   input wire logic issue,
   input wire logic coupler_req,
   input wire logic eot_to_ctrl,
   input wire logic range_error,
   input wire logic p_incr,
   input wire logic fetch_outstanding_flag,
   input wire logic jump_out_flag,
   input wire logic fetch_pending_one,
   input wire logic fetch_pending_two,
   input wire logic memory_wait_one,
   input wire logic memory_wait_two
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // first stack fetch request of a return jump
   sequence s_rj_req;
      mreq.valid && jump_out_flag;
   endsequence
   // all start conditions of a block copy
   sequence s_bc_go;
      bc_start_req && regs_free && ext_store_req && !fetch_pending_one && mstat.mem_enable_nxt;
   endsequence
   chk_rj_flags: assert property (rj_start && issue |=> jump_out_flag && fetch_outstanding_flag
      && fetch_pending_one && fetch_pending_two) else $error("jump flags not set");
   chk_first_req: assert property (s_rj_req |-> mreq.tag == JBS_TAG_STACK ##1 (!jump_out_flag
      && !fetch_pending_two && memory_wait_one && memory_wait_two))
      else $error("first fetch step wrong");
   chk_second_req: assert property (s_rj_req |-> ##2 (mreq.valid && mreq.tag == JBS_TAG_STACK)
      ##1 !fetch_pending_one) else $error("second fetch step wrong");
   chk_blank_word: assert property (fetch_outstanding_flag && memory_wait_two
      |-> current_word_reg == BLANK_WORD) else $error("word not blank while waiting");
   chk_first_stack: assert property (fetch_word_valid && memory_wait_two && !mstat.bank_busy
      |=> !memory_wait_two) else $error("first word not stacked");
   chk_osf_clear: assert property ($fell(memory_wait_two) |=> !fetch_outstanding_flag)
      else $error("outstanding flag not cleared");
   chk_second_stack: assert property (fetch_word_valid && !memory_wait_two && memory_wait_one
      |=> !memory_wait_one) else $error("second word not stacked");
   chk_exit_wait: assert property (rj_start && memory_wait_one |-> !issue)
      else $error("jump issued during fetch wait");
   chk_copy_req: assert property (s_bc_go |-> ##3 (coupler_req || eot_to_ctrl))
      else $error("coupler request late");
   chk_copy_end: assert property (bc_start_req && coupler_eot && !pp_xchg_req && mstat.mem_enable
      |-> !issue ##2 p_incr ##1 issue) else $error("copy end timing wrong");
   chk_range_end: assert property (eot_to_ctrl && coupler_range_err
      |-> ##2 range_error ##2 p_incr ##1 issue) else $error("range error timing wrong");
endmodule : jbs_sequencer_sva
bind jbs_sequencer jbs_sequencer_sva jbs_sequencer_sva_i (.mclk, .rstn, .rj_start, .bc_start_req,
   .ext_store_req, .regs_free, .coupler_range_err, .coupler_eot, .pp_xchg_req, .fetch_word_valid,
   .mstat, .mreq, .current_word_reg, .issue, .coupler_req, .eot_to_ctrl, .range_error, .p_incr,
   .fetch_outstanding_flag, .jump_out_flag, .fetch_pending_one, .fetch_pending_two,
   .memory_wait_one, .memory_wait_two);

// ==== verif/jbs_mem_model.sv ====
// memory controller model answering the stack fetches
`timescale 1ns/100ps
module jbs_mem_model
   import jbs_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire jbs_mreq_t mreq,
   input wire logic backup,
   input wire logic [3:0] busy_extra,
   output jbs_mstat_t mstat,
   output logic [WORD_W-1:0] fetch_word,
   output logic fetch_word_valid
);
   logic en_ff; // memory enable, every other period
   logic bk_ff; // backup seen last period
   logic [5:0] cnt_ff; // periods since first request
   logic [ADDR_W-1:0] a_ff [2]; // the two fetch addresses
   logic [WORD_W-1:0] last_ff; // last word handed over
   logic [5:0] w1; // period of first word
   logic req;
   assign req = mreq.valid && mreq.tag == JBS_TAG_STACK;
   assign w1 = 6'h15 + {2'h0, busy_extra};
   assign fetch_word_valid = cnt_ff != 6'h0 && (cnt_ff == w1 || cnt_ff == w1 + 6'h2);
   // idle data line shows the inverse of the last word
   assign fetch_word = fetch_word_valid ? {42'h2a, a_ff[cnt_ff != w1]} : ~last_ff;
   assign mstat = '{sas_backup: backup, mem_enable: en_ff, mem_enable_nxt: !en_ff,
      backup_resolved: bk_ff && !backup, bank_busy: cnt_ff >= 6'h15 && cnt_ff < w1,
      addr_leave: 1'b0};
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         en_ff <= 1'b0;
         bk_ff <= 1'b0;
         cnt_ff <= 6'h0;
         last_ff <= '0;
      end else begin
         en_ff <= !en_ff;
         bk_ff <= backup;
         if (fetch_word_valid) last_ff <= fetch_word;
         if (req) a_ff[cnt_ff != 6'h0] <= mreq.addr;
         if (cnt_ff == w1 + 6'h2) cnt_ff <= 6'h0;
         else if (cnt_ff != 6'h0 || req) cnt_ff <= cnt_ff + 6'h1;
      end
   end
endmodule : jbs_mem_model

// ==== verif/jbs_sequencer_test.sv ====
// self-checking bench for the jump and block copy sequencer
`timescale 1ns/100ps
module jbs_sequencer_test
   import jbs_pkg::*;
   ;
   typedef struct {logic [ADDR_W-1:0] pa; logic [ADDR_W-1:0] ba; logic [3:0] bz;} jbs_row_t;
   // return jump cases: program address, base, extra bank busy periods
   jbs_row_t rows [3] = '{'{18'h00100, 18'h01000, 4'h0}, '{18'h3ffff, 18'h00002, 4'h0},
      '{18'h12345, 18'h00200, 4'h3}};
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic rj_start = 1'b0, bc_start_req = 1'b0, ext_store_req = 1'b0, regs_free = 1'b1;
   logic ce = 1'b1, xj_done = 1'b0; // clock enable, exchange complete
   logic coupler_range_err = 1'b0, coupler_eot = 1'b0, xfer_err_end = 1'b0, xj_start = 1'b0;
   logic fetch_word_valid, issue, coupler_req, eot_to_ctrl, range_error, p_incr, backup = 1'b0;
   logic fetch_outstanding_flag, jump_out_flag, fetch_pending_one, fetch_pending_two;
   logic memory_wait_one, memory_wait_two;
   logic [3:0] busy_extra = 4'h0;
   logic [ADDR_W-1:0] prog_addr = '0, memory_base_address = '0;
   logic [WORD_W-1:0] fetch_word, current_word_reg, fw;
   logic [WORD_W-1:0] next_instr_word = 60'h0123456789abcde;
   jbs_mstat_t mstat;
   jbs_mreq_t mreq;
   logic [ADDR_W-1:0] q [$]; // fetch addresses seen
   int error_cnt = 0, cmp_count = 0, cyc = 0, iss_cnt = 0, n, m, k;
   jbs_sequencer jbs_sequencer_i (.mclk, .rstn, .ce, .rj_start, .bc_start_req,
      .ext_store_req, .regs_free, .coupler_range_err, .coupler_eot, .xfer_err_end,
      .pp_xchg_req(1'b0), .xj_start, .xj_done, .prog_addr, .memory_base_address,
      .fetch_word, .fetch_word_valid, .next_instr_word, .mstat, .mreq, .current_word_reg,
      .issue, .coupler_req, .eot_to_ctrl, .range_error, .p_incr, .fetch_outstanding_flag,
      .jump_out_flag, .fetch_pending_one, .fetch_pending_two, .memory_wait_one,
      .memory_wait_two, .store_exit_flag(), .next_stack_address());
   jbs_mem_model jbs_mem_model_i (.mclk, .rstn, .mreq, .backup, .busy_extra, .mstat,
      .fetch_word, .fetch_word_valid);
   always #5 mclk = ~mclk;
   // monitor: fetch addresses, issue count, hang limit
   always @(posedge mclk) begin
      cyc++;
      if (mreq.valid === 1'b1) q.push_back(mreq.addr);
      if (issue === 1'b1) iss_cnt++;
      if (cyc == 5000) begin
         error_cnt++;
         summarize();
      end
   end
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   task automatic check(input string nm, input logic [WORD_W-1:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   function automatic logic sel(input int s);
      case (s)
         0: return issue;
         1: return coupler_req;
         2: return p_incr;
         3: return range_error;
         4: return !fetch_outstanding_flag;
         5: return !memory_wait_one;
         default: return memory_wait_one;
      endcase
   endfunction : sel
   // bounded wait at falling edges for a chosen output
   task automatic wait_for(input int s, output int c);
      c = 0;
      while (sel(s) !== 1'b1 && c < 400) begin
         @(negedge mclk);
         c++;
      end
   endtask : wait_for
   // finish a return jump already requested
   task automatic rj_tail(output int c);
      wait_for(0, n);
      @(negedge mclk);
      rj_start = 1'b0;
      wait_for(4, c);
      wait_for(5, n);
   endtask : rj_tail
   task automatic rj_run(input jbs_row_t r);
      prog_addr = r.pa;
      memory_base_address = r.ba;
      busy_extra = r.bz;
      q.delete();
      rj_start = 1'b1;
      rj_tail(m);
      check("osf wait", 60'(m), 60'(23 + r.bz));
      check("word", current_word_reg, {42'h2a, ADDR_W'(r.pa + r.ba)});
      check("addr1", 60'(q[0]), 60'(ADDR_W'(r.pa + r.ba)));
      check("addr2", 60'(q[1]), 60'(ADDR_W'(r.pa + r.ba + 1)));
   endtask : rj_run
   // block copy, normal end or range error end
   task automatic bc(input logic err);
      // let an edge pass so a previous call's releases are sampled first
      @(negedge mclk);
      k = iss_cnt;
      coupler_range_err = err;
      xfer_err_end = err;
      bc_start_req = 1'b1;
      @(negedge mclk);
      if (mstat.mem_enable === 1'b1) @(negedge mclk);
      ext_store_req = 1'b1;
      @(negedge mclk);
      ext_store_req = 1'b0;
      wait_for(err ? 3 : 1, n);
      check("to request", 60'(n), err ? 60'h4 : 60'h2);
      if (!err) begin
         // the coupler owns the transfer only from the period after its request
         @(negedge mclk);
         if (mstat.mem_enable !== 1'b1) @(negedge mclk);
         coupler_eot = 1'b1;
         @(negedge mclk);
         coupler_eot = 1'b0;
      end
      wait_for(2, n);
      check("to p+1", 60'(n), err ? 60'h2 : 60'h1);
      wait_for(0, n);
      check("to issue", 60'(n), 60'h1);
      fw = fetch_word;
      @(negedge mclk);
      bc_start_req = 1'b0;
      coupler_range_err = 1'b0;
      xfer_err_end = 1'b0;
      check("new word", current_word_reg, err ? next_instr_word : fw);
      check("issues", 60'(iss_cnt - k), 60'h1);
   endtask : bc
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(negedge mclk);
      rstn = 1'b1;
      @(negedge mclk);
      check("reset flags", 60'({fetch_outstanding_flag, jump_out_flag, fetch_pending_one,
         fetch_pending_two, memory_wait_one, memory_wait_two}), '0);
      check("reset word", current_word_reg, BLANK_WORD);
      foreach (rows[i]) rj_run(rows[i]);
      // a second jump waits behind fetches still in flight
      rj_start = 1'b1;
      wait_for(0, n);
      @(negedge mclk);
      rj_start = 1'b0;
      wait_for(6, n);
      rj_start = 1'b1;
      wait_for(0, n);
      check("stall", 60'(n > 15), 60'h1);
      rj_tail(m);
      // stage backup holds the store exit period
      backup = 1'b1;
      rj_start = 1'b1;
      k = iss_cnt;
      repeat (6) @(negedge mclk);
      check("held", 60'(iss_cnt - k), 60'h0);
      backup = 1'b0;
      rj_tail(m);
      for (int e = 0; e < 2; e++) bc(e[0]);
      // exchange jump blanks the word; issue waits for both done and the minimum, in either order
      for (int d = 0; d < 2; d++) begin
         xj_start = 1'b1;
         wait_for(0, n);
         @(negedge mclk);
         xj_start = 1'b0;
         check("xj word", current_word_reg, BLANK_WORD);
         k = iss_cnt;
         rj_start = 1'b1;
         xj_done = d[0];
         repeat (99 - 10 * d) @(negedge mclk);
         check("xj hold", 60'(iss_cnt - k), 60'h0);
         xj_done = 1'b1;
         rj_tail(m);
      end
      // clock enable low freezes the whole sequence
      ce = 1'b0;
      rj_start = 1'b1;
      k = iss_cnt;
      repeat (4) @(negedge mclk);
      check("frozen", 60'(iss_cnt - k), 60'h0);
      ce = 1'b1;
      rj_tail(m);
      summarize();
   end
endmodule : jbs_sequencer_test
